// File: logic/wis_frame_align_alarms.sv
// The register addresses and register access over APB were left to the implementer.
`include "wis_frame_align_alarms_cfg.svh"
`default_nettype none

// Contract
// (R1) Transmit A1 octets from programmed A1 value, A2 octets from programmed A2.
// (R2) Receive aligner uses a primary lock machine and a secondary run machine.
// (R3) Sync pattern is f A1 octets then f A2 octets, f 0..16, default 2.
// (R4) f of 0 means A1 plus A2 top nibble; f of 1 means A1A1A2.
// (R5) Hunt pattern is i consecutive A1 octets, i 1..16, default 4.
// (R6) Presync A1 count 1..16, default 16; 0 acts as 1, above 16 as 16.
// (R7) Presync A2 count 0..16, default 16; 0 is top nibble, above 16 as 16.
// (R8) Frame boundaries needed in presync to lock: 1..15, default 4, 0 as 1.
// (R9) Boundary errors that drop lock: 1..15, default 4, 0 as 1.
// (R10) Signal absent status latches high; two reads give event then level.
// (R11) Signal absent event sets pending bit until read; masked onto both irqs.
// (R12) Remote defect code goes into K2 on signal absent when enabled.
// (R13) Alarm fill on signal absent forces payload all ones when enabled.
// (R14) Carrier input change sets pending until read; live level readable; polarity.
// (R15) Carrier pending bit reaches both irqs through its own masks.
// (R16) Remote defect code goes into K2 on carrier loss when enabled.
// (R17) Carrier loss forces frame lost and out of frame when enabled.
// (R18) Alarm fill on carrier loss forces payload all ones when enabled.
// (R19) Reset starts out of frame with SEF and LOF; lock after entry plus one.
// (R20) SEF clears on reaching lock and is declared on entering out of frame.
// (R21) Lock drops after exit count consecutive errored alignment words.
// (R22) SEF status latches high; SEF pending bit masked onto both irqs.
// (R23) Irq is OR of pending AND mask; flags clear on the read returning them.
module wis_frame_align_alarms
  import wis_frame_align_alarms_pkg::*;
#(
  parameter logic [17:0] FRAME_OCTETS = `FRAME_OCTETS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] tx_in_data,
  input wire logic tx_in_sof,
  input wire logic tx_in_k2,
  output logic [7:0] tx_out_data,
  input wire logic [7:0] rx_pma_data,
  output logic [7:0] rx_out_data,
  output logic rx_alarm_fill,
  output logic rx_in_frame,
  output logic rx_frame_boundary,
  output logic rx_frame_lost,
  output logic severe_frame_error,
  input wire logic signal_absent_input,
  input wire logic optical_carrier_gone_input,
  output logic irq_out_a,
  output logic irq_out_b
);

  wfa_state_t s;
  wfa_state_t n;

  logic [15:0] win;
  logic [7:0] b;
  logic sa_live;
  logic cg_live;
  logic fill;
  logic rdi;
  logic force_lof;
  logic sef;
  logic [4:0] hunt_i;
  logic [4:0] pre_j;
  logic [4:0] pre_k;
  logic [4:0] sync_j;
  logic [4:0] sync_k;
  logic [4:0] pre_e;
  logic [4:0] sync_e;
  logic [3:0] entry;
  logic [3:0] exit_n;
  logic pre_hit;
  logic sync_hit;
  logic at_bound;
  logic hunt_lock;
  logic go_hunt;
  logic setup;
  logic acc_wr;
  logic clr_stat;
  logic clr_p1;
  logic clr_p2;
  logic mapped;
  logic [31:0] rdat;
  logic [8:0] tx_idx;
  logic tx_pos;
  logic [2:0] pend;

  // Width clamp: above 16 acts as 16, and zero acts as one where asked
  function automatic logic [4:0] clamp_w(input logic [4:0] v, input logic z1);
    clamp_w = (v > `MAX_WIDTH) ? `MAX_WIDTH : v;
    if (z1 && v == 5'h00) clamp_w = 5'h01;
  endfunction

  // Counts of zero behave as one
  function automatic logic [3:0] min1(input logic [3:0] v);
    min1 = (v == 4'h0) ? 4'h1 : v;
  endfunction

  // Saturating run counter; real frames hold far more octets than 31
  function automatic logic [4:0] sat_inc(input logic [4:0] v);
    sat_inc = (v == 5'h1f) ? v : v + 5'h01;
  endfunction

  // Pattern end seen on this octet: at least j A1s then exactly k A2s
  function automatic logic pat_hit(input run_state_t rs, input logic [4:0] a1run,
                                   input logic [4:0] a2run, input logic [7:0] oct,
                                   input logic [7:0] a2v, input logic [4:0] j,
                                   input logic [4:0] k);
    logic [5:0] c2;
    c2 = (rs == run_a2) ? ({1'b0, a2run} + 6'h01) : 6'h01;
    if (rs == run_idle || a1run < j) begin
      pat_hit = 1'b0;
    end else if (k == 5'h00) begin
      pat_hit = (rs == run_a1) && (oct[7:4] == a2v[7:4]); // [R4] [R7]
    end else begin
      pat_hit = (oct == a2v) && (c2 == {1'b0, k}); // [R3]
    end
  endfunction

  // Pattern widths and counts as the framer really uses them
  always_comb begin
    hunt_i = clamp_w(s.hunt_w, 1'b1); // [R5]
    pre_j = clamp_w(s.pre_j, 1'b1); // [R6]
    pre_k = clamp_w(s.pre_k, 1'b0); // [R7]
    entry = min1(s.entry); // [R8]
    exit_n = min1(s.exit_n); // [R9]
    if (s.sync_w == 5'h00) begin
      sync_j = 5'h01; // [R4]
      sync_k = 5'h00;
    end else if (s.sync_w == 5'h01) begin
      sync_j = 5'h02; // [R4]
      sync_k = 5'h01;
    end else begin
      sync_j = clamp_w(s.sync_w, 1'b1); // [R3]
      sync_k = sync_j;
    end
    // Pattern end sits on the last A2, or on the first one when only a nibble
    pre_e = (pre_k == 5'h00) ? 5'h01 : pre_k;
    sync_e = (sync_k == 5'h00) ? 5'h01 : sync_k;
  end

  // Register read decode; unmapped offsets answer with an error and zero
  always_comb begin
    mapped = 1'b1;
    rdat = '0;
    case (paddr)
      `TXFV_ADDR: rdat = {16'h0000, s.a2v, s.a1v};
      `CFG1_ADDR: rdat = {19'h00000, s.hunt_w, 3'h0, s.sync_w};
      `CFG2_ADDR: rdat = {8'h00, s.exit_n, s.entry, 3'h0, s.pre_k, 3'h0, s.pre_j};
      `ACT_ADDR: rdat = {26'h0000000, s.act};
      `STAT_ADDR: rdat = {26'h0000000, s.ls, sa_live, s.lof, s.sef_lat, s.sa_lat};
      `PEND1_ADDR: rdat = {30'h00000000, s.severe_frame_error_pending, s.sa_pend};
      `PEND2_ADDR: rdat = {30'h00000000, s.cg_sync[1], s.cg_pend}; // [R14]
      `MASK_ADDR: rdat = {21'h000000, s.mask_b, 5'h00, s.mask_a};
      default: mapped = 1'b0;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    n = s;
    win = {rx_pma_data, s.rx_prev};
    b = win[s.offs +: 8];
    sa_live = s.sa_sync[1];
    cg_live = s.cg_sync[1] ^ s.act[`ACT_CG_POL]; // [R14]
    fill = (sa_live & s.act[`ACT_FILL_SA]) | (cg_live & s.act[`ACT_FILL_CG]); // [R13] [R18]
    rdi = (sa_live & s.act[`ACT_RDI_SA]) | (cg_live & s.act[`ACT_RDI_CG]); // [R12] [R16]
    force_lof = cg_live & s.act[`ACT_LOF_CG]; // [R17]
    sef = (s.ls != st_sync); // [R20]
    pre_hit = pat_hit(s.rs, s.a1run, s.a2run, b, s.a2v, pre_j, pre_k);
    sync_hit = pat_hit(s.rs, s.a1run, s.a2run, b, s.a2v, sync_j, sync_k);
    at_bound = (s.fcnt == FRAME_OCTETS - 18'h00001);
    hunt_lock = 1'b0;
    go_hunt = 1'b0;

    // Pins cross two flops; only the second one is looked at
    n.sa_sync = {s.sa_sync[0], signal_absent_input};
    n.cg_sync = {s.cg_sync[0], optical_carrier_gone_input};
    n.sa_q = sa_live;
    n.cg_q = s.cg_sync[1];
    n.sef_q = sef;

    // Read data and side effects are taken in the setup cycle, so the flag
    // cleared is exactly the flag returned; a new event in that cycle survives
    setup = psel & ~penable;
    acc_wr = psel & penable & pwrite;
    clr_stat = setup & ~pwrite & (paddr == `STAT_ADDR);
    clr_p1 = setup & ~pwrite & (paddr == `PEND1_ADDR);
    clr_p2 = setup & ~pwrite & (paddr == `PEND2_ADDR);
    if (setup) begin
      n.prdata = pwrite ? 32'h00000000 : rdat;
      n.pslverr = ~mapped;
    end

    // Writes land at the access edge; read-only offsets ignore them
    if (acc_wr) begin
      case (paddr)
        `TXFV_ADDR: begin
          n.a1v = pwdata[`TXFV_A1];
          n.a2v = pwdata[`TXFV_A2];
        end
        `CFG1_ADDR: begin
          n.sync_w = pwdata[`CFG1_SYNC_W];
          n.hunt_w = pwdata[`CFG1_HUNT_W];
        end
        `CFG2_ADDR: begin
          n.pre_j = pwdata[`CFG2_PRE_J];
          n.pre_k = pwdata[`CFG2_PRE_K];
          n.entry = pwdata[`CFG2_ENTRY];
          n.exit_n = pwdata[`CFG2_EXIT];
        end
        `ACT_ADDR: n.act = pwdata[`ACT_FIELD];
        `MASK_ADDR: begin
          n.mask_a = pwdata[`MASK_A];
          n.mask_b = pwdata[`MASK_B];
        end
        default: ;
      endcase
    end

    // Latch-high status reloads with the live level when read; set wins
    n.sa_lat = sa_live | (s.sa_lat & ~clr_stat); // [R10] [R23]
    n.sef_lat = sef | (s.sef_lat & ~clr_stat); // [R22] [R23]
    n.sa_pend = (sa_live & ~s.sa_q) | (s.sa_pend & ~clr_p1); // [R11]
    n.severe_frame_error_pending = (sef ^ s.sef_q) | (s.severe_frame_error_pending & ~clr_p1); // [R22]
    n.cg_pend = (s.cg_sync[1] ^ s.cg_q) | (s.cg_pend & ~clr_p2); // [R14]

    // Transmit framing octets counted from the first A1 of each frame
    tx_idx = tx_in_sof ? 9'h000 : s.tx_cnt;
    tx_pos = tx_in_sof | s.tx_act;
    n.tx_cnt = tx_idx + 9'h001;
    n.tx_act = tx_pos && (tx_idx != `A12_LAST);
    if (tx_pos && tx_idx < `A1_OCTETS) begin
      n.tx_data = s.a1v; // [R1]
    end else if (tx_pos) begin
      n.tx_data = s.a2v; // [R1]
    end else if (tx_in_k2 && rdi) begin
      n.tx_data = {tx_in_data[7:3], `RDI_L_CODE}; // [R12] [R16]
    end else begin
      n.tx_data = tx_in_data;
    end

    // Secondary machine: tracks the A1 run and the A2 run behind it
    n.rx_prev = rx_pma_data;
    unique case (s.rs)
      run_idle: begin
        if (b == s.a1v) begin
          n.rs = run_a1; // [R2]
          n.a1run = 5'h01;
        end
      end
      run_a1: begin
        if (b == s.a1v) begin
          n.a1run = sat_inc(s.a1run);
        end else if (b == s.a2v) begin
          n.rs = run_a2; // [R2]
          n.a2run = 5'h01;
        end else begin
          n.rs = run_idle;
        end
      end
      run_a2: begin
        if (b == s.a2v) begin
          n.a2run = sat_inc(s.a2run);
        end else if (b == s.a1v) begin
          n.rs = run_a1;
          n.a1run = 5'h01;
        end else begin
          n.rs = run_idle;
        end
      end
      default: n.rs = run_idle;
    endcase

    // Primary machine: hunt bit offset, seek presync, confirm, hold lock
    n.fcnt = at_bound ? 18'h00000 : s.fcnt + 18'h00001;
    n.bound = 1'b0;
    unique case (s.ls)
      st_hunt: begin
        for (int o = 7; o >= 0; o--) begin
          n.hrun[o] = (win[o +: 8] == s.a1v) ? sat_inc(s.hrun[o]) : 5'h00;
          if (n.hrun[o] >= hunt_i) begin
            n.offs = 3'(o); // [R5] lowest offset wins
            hunt_lock = 1'b1;
          end
        end
        if (hunt_lock) begin
          n.ls = st_seek; // [R2]
          n.rs = run_idle;
          n.fcnt = 18'h00000;
        end
      end
      st_seek: begin
        if (pre_hit) begin
          n.ls = st_presync; // [R6] [R7]
          // Boundaries are timed on the sync pattern end, not the presync end;
          // a longer sync pattern counts its end in this frame as the first one
          if (pre_e >= sync_e) begin
            n.fcnt = 18'(pre_e - sync_e);
          end else begin
            n.fcnt = FRAME_OCTETS - 18'(sync_e - pre_e);
          end
          n.cnt = 4'h0;
        end else if (at_bound) begin
          go_hunt = 1'b1;
        end
      end
      st_presync: begin
        if (at_bound && sync_hit) begin
          n.bound = 1'b1;
          n.cnt = s.cnt + 4'h1;
          if (s.cnt + 4'h1 >= entry) begin
            n.ls = st_sync; // [R8] [R19] presync match plus entry boundaries
            n.cnt = 4'h0;
          end
        end else if (at_bound) begin
          go_hunt = 1'b1;
        end
      end
      st_sync: begin
        if (at_bound && sync_hit) begin
          n.bound = 1'b1;
          n.cnt = 4'h0;
        end else if (at_bound) begin
          n.cnt = s.cnt + 4'h1;
          if (s.cnt + 4'h1 >= exit_n) begin
            go_hunt = 1'b1; // [R9] [R21]
          end
        end
      end
    endcase
    if (go_hunt || force_lof) begin
      n.ls = st_hunt; // [R17] [R20] out of frame
      n.hrun = '0;
      n.cnt = 4'h0;
    end

    // Frame lost holds from reset until lock, and while carrier loss forces it
    n.lof = force_lof | (s.lof & (n.ls != st_sync)); // [R17] [R19]
    n.fill = fill;
    n.rx_data = fill ? 8'hff : b; // [R13] [R18]
  end

  // Whole state in one register; reset gives an unlocked framer with alarms on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.a1v <= `A1_RST; // [R1]
      s.a2v <= `A2_RST; // [R1]
      s.sync_w <= `SYNC_W_RST; // [R3]
      s.hunt_w <= `HUNT_W_RST; // [R5]
      s.pre_j <= `PRE_J_RST; // [R6]
      s.pre_k <= `PRE_K_RST; // [R7]
      s.entry <= `ENTRY_RST; // [R8]
      s.exit_n <= `EXIT_RST; // [R9]
      s.rs <= run_idle;
      s.ls <= st_hunt; // [R19]
      s.lof <= 1'b1; // [R19]
      s.sef_q <= 1'b1;
      s.sef_lat <= 1'b1; // [R19]
    end else begin
      s <= n;
    end
  end

  // Interrupts: OR over sources of pending AND mask
  assign pend = {s.cg_pend, s.severe_frame_error_pending, s.sa_pend};
  assign irq_out_a = |(pend & s.mask_a); // [R11] [R15] [R22] [R23]
  assign irq_out_b = |(pend & s.mask_b); // [R11] [R15] [R22] [R23]

  // Zero-wait slave: the access phase always completes in its first cycle
  assign pready = psel & penable;
  assign pslverr = psel & penable & s.pslverr;
  assign prdata = s.prdata;
  assign tx_out_data = s.tx_data;
  assign rx_out_data = s.rx_data;
  assign rx_alarm_fill = s.fill;
  assign rx_in_frame = (s.ls == st_sync);
  assign rx_frame_boundary = s.bound;
  assign rx_frame_lost = s.lof;
  assign severe_frame_error = (s.ls != st_sync); // [R20]

endmodule

`default_nettype wire

// File: inc/wis_frame_align_alarms_cfg.svh
`ifndef WIS_FRAME_ALIGN_ALARMS_CFG_SVH
`define WIS_FRAME_ALIGN_ALARMS_CFG_SVH

// Register byte offsets on the APB
`define TXFV_ADDR 8'h00
`define CFG1_ADDR 8'h04
`define CFG2_ADDR 8'h08
`define ACT_ADDR 8'h0c
`define STAT_ADDR 8'h10
`define PEND1_ADDR 8'h14
`define PEND2_ADDR 8'h18
`define MASK_ADDR 8'h1c

// Field positions
`define TXFV_A1 7:0
`define TXFV_A2 15:8
`define CFG1_SYNC_W 4:0
`define CFG1_HUNT_W 12:8
`define CFG2_PRE_J 4:0
`define CFG2_PRE_K 12:8
`define CFG2_ENTRY 19:16
`define CFG2_EXIT 23:20
`define ACT_FIELD 5:0
`define ACT_RDI_SA 0
`define ACT_FILL_SA 1
`define ACT_RDI_CG 2
`define ACT_LOF_CG 3
`define ACT_FILL_CG 4
`define ACT_CG_POL 5
`define MASK_A 2:0
`define MASK_B 10:8

// Reset values
`define A1_RST 8'hf6
`define A2_RST 8'h28
`define SYNC_W_RST 5'h02
`define HUNT_W_RST 5'h04
`define PRE_J_RST 5'h10
`define PRE_K_RST 5'h10
`define ENTRY_RST 4'h4
`define EXIT_RST 4'h4

// Framing geometry and codes
`define FRAME_OCTETS 18'h25f80
`define A1_OCTETS 9'h0c0
`define A12_LAST 9'h17f
`define MAX_WIDTH 5'h10
`define RDI_L_CODE 3'h6

`endif

// File: inc/wis_frame_align_alarms_pkg.sv
`default_nettype none

package wis_frame_align_alarms_pkg;

  typedef enum logic [1:0] {st_hunt, st_seek, st_presync, st_sync} lock_state_t;
  typedef enum logic [1:0] {run_idle, run_a1, run_a2} run_state_t;

  typedef struct packed {
    logic [7:0] a1v;
    logic [7:0] a2v;
    logic [4:0] sync_w;
    logic [4:0] hunt_w;
    logic [4:0] pre_j;
    logic [4:0] pre_k;
    logic [3:0] entry;
    logic [3:0] exit_n;
    logic [5:0] act;
    logic [2:0] mask_a;
    logic [2:0] mask_b;
    logic [1:0] sa_sync;
    logic [1:0] cg_sync;
    logic sa_q;
    logic cg_q;
    logic sef_q;
    logic sa_lat;
    logic sef_lat;
    logic sa_pend;
    logic severe_frame_error_pending;
    logic cg_pend;
    logic [31:0] prdata;
    logic pslverr;
    logic [8:0] tx_cnt;
    logic tx_act;
    logic [7:0] tx_data;
    logic [7:0] rx_prev;
    logic [2:0] offs;
    logic [7:0][4:0] hrun;
    run_state_t rs;
    logic [4:0] a1run;
    logic [4:0] a2run;
    lock_state_t ls;
    logic [17:0] fcnt;
    logic [3:0] cnt;
    logic lof;
    logic bound;
    logic fill;
    logic [7:0] rx_data;
  } wfa_state_t;

endpackage

`default_nettype wire

// File: sim/wis_frame_align_alarms_props.sv
`default_nettype none

module wis_frame_align_alarms_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_in_sof,
  input wire logic [7:0] tx_out_data,
  input wire logic [7:0] rx_out_data,
  input wire logic rx_alarm_fill,
  input wire logic rx_in_frame,
  input wire logic rx_frame_boundary,
  input wire logic rx_frame_lost,
  input wire logic severe_frame_error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Bus timing: no wait states, error only in access
  a_pready_zero_wait: assert property (pready == (psel && penable))
    else $error("pready outside access phase");
  a_error_in_access: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_read_data_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("prdata moved outside setup");

  // Framer alarms follow lock state
  a_sef_not_locked: assert property (severe_frame_error == !rx_in_frame)
    else $error("SEF not the inverse of lock");
  a_lost_clears_sync: assert property ($fell(rx_frame_lost) |-> rx_in_frame)
    else $error("LOF cleared without lock");
  a_lost_drops_soon: assert property ($rose(rx_in_frame) |-> ##[0:1] !rx_frame_lost)
    else $error("LOF kept after lock");
  a_sync_on_boundary: assert property ($rose(rx_in_frame) |->
    rx_frame_boundary || $past(rx_frame_boundary))
    else $error("lock without boundary");

  // Fill and transmit framing octets
  a_fill_all_ones: assert property (rx_alarm_fill && $past(rx_alarm_fill) |->
    rx_out_data == 8'hff)
    else $error("payload not all ones under fill");
  a_tx_value_holds: assert property (tx_in_sof ##1 !tx_in_sof |=> $stable(tx_out_data))
    else $error("A1 octets not constant");
endmodule

bind wis_frame_align_alarms wis_frame_align_alarms_props i_props (
  .pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr, .tx_in_sof,
  .tx_out_data, .rx_out_data, .rx_alarm_fill, .rx_in_frame, .rx_frame_boundary,
  .rx_frame_lost, .severe_frame_error
);

`default_nettype wire

// File: sim/pma_frame_source.sv
`default_nettype none

module pma_frame_source #(
  parameter int FRAME = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bad,
  output logic [7:0] rx_pma_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos;

  // Octet position within the short simulation frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos <= 0;
    end else begin
      pos <= (pos == FRAME - 1) ? 0 : pos + 1;
    end
  end

  // 20 A1, 20 A2, then zero filler; a spoiled frame loses its A2 run
  // Hunt uses up the first 4 A1s, so 16 must still follow for presync
  assign rx_pma_data = (pos < 20) ? 8'hf6 : (pos < 40 && !bad) ? 8'h28 : 8'h00;
endmodule

`default_nettype wire

// File: sim/wis_frame_align_alarms_tb.sv
`include "wis_frame_align_alarms_cfg.svh"
`default_nettype none

module wis_frame_align_alarms_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FR = 64;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_in_sof, tx_in_k2;
  logic [7:0] paddr, tx_in_data, tx_out_data, rx_pma_data, rx_out_data;
  logic [31:0] pwdata, prdata, rdat;
  logic rx_alarm_fill, rx_in_frame, rx_frame_boundary, rx_frame_lost, severe_frame_error;
  logic signal_absent_input, optical_carrier_gone_input, irq_out_a, irq_out_b, bad, rerr;
  int miscompares = 0;
  int n_checks = 0;

  wis_frame_align_alarms #(.FRAME_OCTETS(18'(FR))) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tx_in_data, .tx_in_sof, .tx_in_k2, .tx_out_data, .rx_pma_data,
    .rx_out_data, .rx_alarm_fill, .rx_in_frame, .rx_frame_boundary, .rx_frame_lost,
    .severe_frame_error, .signal_absent_input, .optical_carrier_gone_input,
    .irq_out_a, .irq_out_b
  );

  pma_frame_source #(.FRAME(FR)) i_pma (.pclk, .presetn, .bad, .rx_pma_data);

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %0t %h %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(rdat & m, e);
  endtask

  // K2 octet through transmit; output seen at the following edge
  task automatic k2(input logic [7:0] e);
    @(posedge pclk);
    tx_in_k2 <= 1'b1;
    @(posedge pclk);
    tx_in_k2 <= 1'b0;
    @(posedge pclk);
    chk(32'(tx_out_data), 32'(e));
  endtask

  task automatic summarize();
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {psel, penable, pwrite, tx_in_sof, tx_in_k2, bad, presetn} = '0;
    {signal_absent_input, optical_carrier_gone_input} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tx_in_data = 8'hf9;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(severe_frame_error), 1);
    chk(32'(rx_frame_lost), 1);
    rd(`TXFV_ADDR, '1, 32'h0000_28f6);
    rd(`CFG1_ADDR, '1, 32'h0000_0402);
    rd(`CFG2_ADDR, '1, 32'h0044_1010);
    rd(8'h20, '1, 32'h0);
    chk(32'(rerr), 1);
    // Exit count zero acts as one: one spoiled frame drops lock
    apb(`CFG2_ADDR, 1'b1, 32'h0004_1010);
    cyc(12 * FR);
    chk(32'(rx_in_frame), 1);
    chk(32'(rx_frame_lost), 0);
    rd(`STAT_ADDR, 32'h2, 32'h2);
    rd(`STAT_ADDR, 32'h2, 32'h0);
    rd(`PEND1_ADDR, 32'h2, 32'h2);
    bad <= 1'b1;
    cyc(FR);
    bad <= 1'b0;
    cyc(2 * FR);
    chk(32'(rx_in_frame), 0);
    chk(32'(severe_frame_error), 1);
    apb(`CFG1_ADDR, 1'b1, 32'h0000_0401);
    cyc(12 * FR);
    chk(32'(rx_in_frame), 1);
    // Signal absent pulse reaches irq A only
    apb(`MASK_ADDR, 1'b1, 32'h0000_0001);
    signal_absent_input <= 1'b1;
    cyc(4);
    signal_absent_input <= 1'b0;
    cyc(4);
    chk(32'(irq_out_a), 1);
    chk(32'(irq_out_b), 0);
    rd(`STAT_ADDR, 32'h9, 32'h1);
    rd(`STAT_ADDR, 32'h9, 32'h0);
    rd(`PEND1_ADDR, 32'h1, 32'h1);
    rd(`PEND1_ADDR, 32'h1, 32'h0);
    chk(32'(irq_out_a), 0);
    // Signal absent with remote defect and fill enabled
    apb(`ACT_ADDR, 1'b1, 32'h0000_0003);
    signal_absent_input <= 1'b1;
    cyc(4);
    chk(32'(rx_alarm_fill), 1);
    chk(32'(rx_out_data), 32'hff);
    k2(8'hfe);
    signal_absent_input <= 1'b0;
    apb(`ACT_ADDR, 1'b1, 32'h0);
    k2(8'hf9);
    // Carrier loss: forced LOF, fill, remote defect, irq B
    apb(`ACT_ADDR, 1'b1, 32'h0000_001c);
    apb(`MASK_ADDR, 1'b1, 32'h0000_0400);
    optical_carrier_gone_input <= 1'b1;
    cyc(4);
    chk(32'(rx_frame_lost), 1);
    chk(32'(rx_in_frame), 0);
    chk(32'(rx_alarm_fill), 1);
    chk(32'(irq_out_b), 1);
    chk(32'(irq_out_a), 0);
    k2(8'hfe);
    rd(`PEND2_ADDR, 32'h3, 32'h3);
    rd(`PEND2_ADDR, 32'h1, 32'h0);
    chk(32'(irq_out_b), 0);
    // Active-low pin: high means carrier present
    apb(`CFG1_ADDR, 1'b1, 32'h0000_0400);
    apb(`ACT_ADDR, 1'b1, 32'h0000_0028);
    cyc(12 * FR);
    chk(32'(rx_in_frame), 1);
    optical_carrier_gone_input <= 1'b0;
    cyc(4);
    chk(32'(rx_frame_lost), 1);
    rd(`PEND2_ADDR, 32'h1, 32'h1);
    // Programmed framing octets, then pass-through
    apb(`TXFV_ADDR, 1'b1, 32'h0000_5a3c);
    tx_in_data <= 8'h77;
    tx_in_sof <= 1'b1;
    @(posedge pclk);
    tx_in_sof <= 1'b0;
    for (int i = 0; i < 384; i++) begin
      @(posedge pclk);
      chk(32'(tx_out_data), (i < 192) ? 32'h3c : 32'h5a);
    end
    @(posedge pclk);
    chk(32'(tx_out_data), 32'h77);
    summarize();
  end

  // Watchdog far beyond the expected run of about 3000 cycles
  initial begin
    cyc(20000);
    miscompares++;
    summarize();
  end
endmodule

`default_nettype wire
